/* hdl/sipc_decoder.sv */
// Servo command-line decoder: enable, direction/trigger and count lines to motion commands.
`timescale 1ns/10ps
`include "sipc_params.svh"
// Functional notes
// (R1) Burst mode: line_a direction, line_b pulse per unit.
// (R2) Controller keeps burst rate above speed limit.
// (R3) Short enable pulse selects alternate speed once.
// (R4) Resolution equals line_b pulses per revolution.
// (R5) Bidirectional sensor mode serves up to 16 stops.
// (R6) After homing, trigger moves toward line_a direction.
// (R7) Stop when sensor count equals trigger count.
// (R8) Brief enable drop is a trigger, not disable.
// (R9) Same-direction triggers accumulate into more sensors.
// (R10) Finish current direction before reversing.
// (R11) Homing first enable or every enable, required.
// (R12) Disable delay grows with trigger width setting.
// (R13) Sensorless mode: line_a edge starts fixed-direction move.
// (R14) Sensorless mode stops when counts match.
// (R15) Home-to-sensor mode: home on line_a, enable triggers.
// (R16) Rapid triggers extend one continuous move.
// (R17) PWM duty maps proportionally between two limits.
// (R18) line_a high locks follow-mode position.
// (R19) No line_b edge for 50 ms: fault, hold.
// (R20) Near 0/100% duty gives position 0/1.
// (R21) Controller keeps PWM between 20 Hz and 30 kHz.
// (R22) Frequency mode maps frequency between limits, lockable.
// (R23) Minimum frequency is position 0, maximum position 1.
// (R24) Controller keeps frequency 20 Hz to 700 kHz.
// (R25) Controller holds each burst phase 750 ns minimum.
// (R26) Long enable low disables and clears pending counts.
// (R27) All three lines synchronised before edge detection.
module sipc_decoder
  import sipc_pkg::*;
#(
  parameter int CLK_HZ     = `SIPC_CLK_HZ,
  parameter int LOSS_CYC   = `SIPC_LOSS_CYC,
  parameter int MAX_STOPS  = `SIPC_MAX_STOPS,
  parameter int FIFO_DEPTH = `SIPC_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // Command pins
  input  wire logic        enable_in,
  input  wire logic        line_a_in,
  input  wire logic        line_b_in,
  // Configuration
  input  wire logic [2:0]  cfg_mode,
  input  wire logic [15:0] cfg_trig_width,
  input  wire logic [15:0] cfg_resolution,
  input  wire logic        cfg_a_rise,
  input  wire logic        cfg_fixed_dir,
  input  wire logic        cfg_home_every,
  input  wire logic [15:0] cfg_pos0,
  input  wire logic [15:0] cfg_pos1,
  input  wire logic [19:0] cfg_freq_min,
  input  wire logic [19:0] cfg_freq_max,
  // Motion engine handshake
  input  wire logic        home_done,
  input  wire logic        motion_stopped,
  input  wire logic        step_ready,
  // Motion commands and status
  output logic             energized,
  output logic             alt_speed,
  output logic             home_req,
  output logic             move_run,
  output logic             move_dir,
  output logic             decel_req,
  output logic             step_valid,
  output logic             step_dir,
  output logic             rev_tick,
  output logic             burst_overrun,
  output logic             cmd_fault,
  output logic [15:0]      target_pos
);
  localparam int CW = `SIPC_CNT_W;
  localparam int NW = `SIPC_DIV_N;
  localparam int DW = `SIPC_DEN_W;
  localparam int FS = `SIPC_FRAC_SH;
  localparam logic [CW-1:0] LOSS_V = CW'(LOSS_CYC);
  localparam logic [CW-1:0] CNT_MAX = '1;
  localparam logic [4:0] STOP_MAX = 5'(MAX_STOPS);
  localparam logic [5:0] DIV_LAST = 6'(NW - 1);

  if (LOSS_CYC < 1 || LOSS_CYC >= (1 << CW) || MAX_STOPS < 1 || MAX_STOPS > 31 ||
      CLK_HZ < 1 || FIFO_DEPTH < 2) begin : g_bad_cfg
    $error("sipc_decoder: parameter out of range");
  end

  sipc_st_s   r, n;
  sipc_mode_e mode;
  logic [2:0] nf;
  logic [2:0] lv;
  logic [2:0] chg;
  logic [2:0] rise;
  logic [2:0] fall;
  logic       ms_mode;
  logic       fol;
  logic       trig;
  logic       start;
  logic       dreq;
  logic       push;
  logic       fifo_in_ready;

  assign mode = sipc_mode_e'(cfg_mode);

  // A level is taken once the second and third stages agree, filtering one-cycle glitches.
  for (genvar i = 0; i < 3; i++) begin : g_sync
    assign nf[i] = (r.s2[i] == r.s3[i]) ? r.s3[i] : r.filt[i]; // [R27]
  end

  assign lv      = nf;
  assign chg     = nf ^ r.filt;
  assign rise    = chg & nf;
  assign fall    = chg & ~nf;
  assign ms_mode = (mode == SIPC_M_MS_BI) || (mode == SIPC_M_MS_SL) || (mode == SIPC_M_MS_HS);
  assign fol     = (mode == SIPC_M_PWM) || (mode == SIPC_M_FREQ);
  // An enable that returns while still energized was short enough to be a trigger.
  assign trig    = rise[0] && r.energized; // [R8]
  assign start   = (mode == SIPC_M_MS_SL) ? (cfg_a_rise ? rise[1] : fall[1]) : trig; // [R13] [R15]
  assign dreq    = (mode == SIPC_M_MS_BI) ? lv[1] : cfg_fixed_dir; // [R6] [R13]
  assign push    = (mode == SIPC_M_BURST) && r.energized && rise[2]; // [R1]

  sipc_fifo #(
    .W     (1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .resetn    (resetn),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (lv[1]),
    .out_valid (step_valid),
    .out_ready (step_ready),
    .out_data  (step_dir)
  );

  always_comb begin
    logic [DW:0]           tr;
    logic [NW-1:0]         num;
    logic [15:0]           frac;
    logic signed [16:0]    span;
    logic signed [33:0]    prod;
    tr     = '0;
    num    = '0;
    frac   = '0;
    span   = '0;
    prod   = '0;
    n      = r;
    n.s1   = {line_b_in, line_a_in, enable_in};
    n.s2   = r.s1;
    n.s3   = r.s2;
    n.filt = nf;
    n.decel    = 1'b0;
    n.rev_tick = 1'b0;

    // Enable line: low time decides between trigger and disable.
    if (lv[0]) begin
      n.low_cnt = '0;
    end else if (r.low_cnt != cfg_trig_width) begin
      n.low_cnt = r.low_cnt + 16'h1;
    end
    if (rise[0] && !r.energized) begin
      n.energized = 1'b1;
      if (ms_mode && (cfg_home_every || !r.homed_once)) begin
        n.home_req = 1'b1; // [R11]
        n.homed    = 1'b0;
      end
    end
    if (r.home_req && home_done) begin
      n.home_req   = 1'b0;
      n.homed      = 1'b1;
      n.homed_once = 1'b1;
    end
    if (trig && (mode == SIPC_M_BURST || mode == SIPC_M_MS_SL)) begin
      n.alt_pend = 1'b1; // [R3]
    end

    // Pulse-burst stream with per-revolution count.
    if (push) begin
      if (!fifo_in_ready) begin
        n.overrun = 1'b1;
      end else begin
        if (!step_valid) begin
          n.alt_speed = r.alt_pend; // [R3]
          n.alt_pend  = 1'b0;
        end
        if (r.rev_cnt == cfg_resolution - 16'h1) begin
          n.rev_cnt  = '0; // [R4]
          n.rev_tick = 1'b1;
        end else begin
          n.rev_cnt = r.rev_cnt + 16'h1; // [R1]
        end
      end
    end

    // Multi-sensor moves: triggers counted against rising sensor edges on line_b.
    if (ms_mode && r.energized && r.homed) begin
      unique case (r.ms)
        SIPC_MS_IDLE: begin
          if (start) begin
            n.ms        = SIPC_MS_RUN;
            n.move_run  = 1'b1;
            n.move_dir  = dreq; // [R6]
            n.trig_cnt  = 5'h1;
            n.sens_cnt  = '0;
            n.alt_speed = r.alt_pend;
            n.alt_pend  = 1'b0;
          end
        end
        SIPC_MS_RUN: begin
          if (start && dreq == r.move_dir) begin
            if (r.trig_cnt != STOP_MAX) begin
              n.trig_cnt = r.trig_cnt + 5'h1; // [R5] [R9] [R16]
            end
          end else if (start) begin
            // Opposite requests wait until the current direction is finished.
            if (r.q_cnt != STOP_MAX) begin
              n.q_cnt = r.q_cnt + 5'h1; // [R10]
            end
            n.q_dir = dreq;
          end
          if (rise[2]) begin
            n.sens_cnt = r.sens_cnt + 5'h1;
            if (n.sens_cnt == n.trig_cnt) begin
              n.ms       = SIPC_MS_STOP; // [R7] [R14]
              n.move_run = 1'b0;
              n.decel    = 1'b1;
            end
          end
        end
        SIPC_MS_STOP: begin
          // A trigger during the ramp-down is a separate move, not an extension.
          if (start && (r.q_cnt == '0 || dreq == r.q_dir) && r.q_cnt != STOP_MAX) begin
            n.q_cnt = r.q_cnt + 5'h1;
            n.q_dir = dreq;
          end
          if (motion_stopped) begin
            if (n.q_cnt != '0) begin
              n.ms        = SIPC_MS_RUN; // [R10]
              n.move_run  = 1'b1;
              n.move_dir  = n.q_dir;
              n.trig_cnt  = n.q_cnt;
              n.sens_cnt  = '0;
              n.q_cnt     = '0;
              n.alt_speed = n.alt_pend;
              n.alt_pend  = 1'b0;
            end else begin
              n.ms = SIPC_MS_IDLE;
            end
          end
        end
        default: begin
          n.ms = SIPC_MS_IDLE;
        end
      endcase
    end

    // Follow modes: period, high time and loss-of-modulation watch on line_b.
    if (rise[2]) begin
      n.per_cnt  = CW'(1);
      n.high_cnt = CW'(1);
    end else begin
      if (r.per_cnt != CNT_MAX) begin
        n.per_cnt = r.per_cnt + CW'(1);
      end
      if (lv[2] && r.high_cnt != CNT_MAX) begin
        n.high_cnt = r.high_cnt + CW'(1);
      end
    end
    if (fall[2]) begin
      n.high_lat = r.high_cnt;
    end
    if (chg[2]) begin
      n.idle_cnt = '0;
      n.fault    = 1'b0;
    end else begin
      if (r.idle_cnt != CNT_MAX) begin
        n.idle_cnt = r.idle_cnt + CW'(1);
      end
      if (fol && r.idle_cnt >= LOSS_V) begin
        n.fault = 1'b1; // [R19] [R24]
      end
    end

    // Shared restoring divider; frequency mode runs it twice.
    if (r.dv == SIPC_DV_IDLE) begin
      if (fol && r.energized && rise[2] && !lv[1] && !r.fault) begin
        n.dv     = SIPC_DV_P1;
        n.dv_cnt = '0;
        n.rem    = '0;
        n.den    = DW'(r.per_cnt);
        if (mode == SIPC_M_PWM) begin
          n.quo = NW'({r.high_lat, 16'h0}); // [R17]
        end else begin
          n.quo = NW'(CLK_HZ); // [R22]
        end
      end
    end else begin
      tr     = {r.rem[DW-1:0], r.quo[NW-1]};
      n.quo  = {r.quo[NW-2:0], 1'b0};
      n.rem  = tr;
      if (tr >= {1'b0, r.den}) begin
        n.rem    = tr - {1'b0, r.den};
        n.quo[0] = 1'b1;
      end
      n.dv_cnt = r.dv_cnt + 6'h1;
      if (r.dv_cnt == DIV_LAST) begin
        if (r.dv == SIPC_DV_P1 && mode == SIPC_M_FREQ) begin
          num      = (n.quo > NW'(cfg_freq_min)) ? n.quo - NW'(cfg_freq_min) : '0; // [R23]
          n.quo    = {num[NW-FS-1:0], 16'h0};
          n.den    = DW'(cfg_freq_max - cfg_freq_min);
          n.rem    = '0;
          n.dv_cnt = '0;
          n.dv     = SIPC_DV_P2;
        end else begin
          // Fractions at or above one clamp to position 1.
          frac = (n.quo > NW'(`SIPC_FRAC_MAX)) ? `SIPC_FRAC_MAX : n.quo[15:0]; // [R20] [R23]
          span = $signed({1'b0, cfg_pos1}) - $signed({1'b0, cfg_pos0});
          prod = span * $signed({1'b0, frac});
          if (!lv[1] && !r.fault) begin // [R18]
            n.target = (frac == `SIPC_FRAC_MAX) ? cfg_pos1 : cfg_pos0 + prod[31:16]; // [R23]
          end
          n.dv = SIPC_DV_IDLE;
        end
      end
    end

    // A long enable low is a disable: pending moves and counts are dropped; buffered steps still drain.
    if (!lv[0] && r.energized && r.low_cnt == cfg_trig_width) begin
      n.energized = 1'b0; // [R12] [R26]
      n.home_req  = 1'b0;
      n.alt_pend  = 1'b0;
      n.alt_speed = 1'b0;
      n.move_run  = 1'b0;
      n.ms        = SIPC_MS_IDLE;
      n.trig_cnt  = '0;
      n.sens_cnt  = '0;
      n.q_cnt     = '0;
      n.overrun   = 1'b0;
      n.dv        = SIPC_DV_IDLE;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign energized     = r.energized;
  assign alt_speed     = r.alt_speed;
  assign home_req      = r.home_req;
  assign move_run      = r.move_run;
  assign move_dir      = r.move_dir;
  assign decel_req     = r.decel;
  assign rev_tick      = r.rev_tick;
  assign burst_overrun = r.overrun;
  assign cmd_fault     = r.fault;
  assign target_pos    = r.target;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  chk_unit_per_pulse: assert property ( // [R1]
    push && fifo_in_ready |=> r.rev_tick || r.rev_cnt == $past(r.rev_cnt) + 16'h1)
    else $error("burst pulse did not advance one unit");
  chk_rev_tick_count: assert property ( // [R4]
    r.rev_tick |-> $past(r.rev_cnt) == $past(cfg_resolution) - 16'h1 && r.rev_cnt == '0)
    else $error("revolution tick at wrong count");
  chk_trig_stays_on: assert property ( // [R8]
    trig |=> r.energized) else $error("trigger treated as disable");
  chk_disable_delay: assert property ( // [R12]
    $fell(r.energized) |-> $past(r.low_cnt) == $past(cfg_trig_width))
    else $error("disable before trigger width elapsed");
  chk_disable_clears: assert property ( // [R26]
    !r.energized |-> r.trig_cnt == '0 && r.q_cnt == '0 && !r.move_run)
    else $error("pending counts kept while disabled");
  chk_stop_at_count: assert property ( // [R7]
    r.decel |-> r.sens_cnt == r.trig_cnt && !r.move_run && r.ms == SIPC_MS_STOP)
    else $error("stop without matching sensor count");
  chk_dir_held: assert property ( // [R10]
    r.move_run && $past(r.move_run) |-> $stable(r.move_dir))
    else $error("direction changed during a move");
  chk_home_first: assert property ( // [R11]
    $rose(r.move_run) |-> r.homed) else $error("move before homing");
  chk_stop_limit: assert property ( // [R5]
    r.trig_cnt <= STOP_MAX && r.q_cnt <= STOP_MAX) else $error("stop count above limit");
  chk_loss_fault: assert property ( // [R19]
    fol && r.idle_cnt >= LOSS_V && !chg[2] |=> r.fault ##1 $stable(r.target))
    else $error("loss of modulation not flagged");
  chk_lock_hold: assert property ( // [R18]
    fol && lv[1] |=> $stable(r.target)) else $error("position moved while locked");
endmodule

/* hdl/sipc_fifo.sv */
// Small ring FIFO with a registered head stage for the burst step stream.
`timescale 1ns/10ps
module sipc_fifo #(
  parameter int W     = 1,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         resetn,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1) begin : g_bad_cfg
    $error("sipc_fifo: DEPTH must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp, rp;
    logic [AW:0]             cnt;
    logic                    ov;
    logic [W-1:0]            od;
  } sipc_fifo_s;

  sipc_fifo_s r, n;
  logic       pop;
  logic       push;

  assign in_ready  = r.cnt != (AW+1)'(DEPTH);
  assign out_valid = r.ov;
  assign out_data  = r.od;

  always_comb begin
    n    = r;
    push = in_valid && in_ready;
    pop  = (r.cnt != '0) && (!r.ov || out_ready);
    if (push) begin
      n.mem[r.wp] = in_data;
      n.wp        = r.wp + AW'(1);
    end
    if (r.ov && out_ready) begin
      n.ov = 1'b0;
    end
    // The head stage keeps the outputs on flops; it adds one word of capacity.
    if (pop) begin
      n.od = r.mem[r.rp];
      n.ov = 1'b1;
      n.rp = r.rp + AW'(1);
    end
    n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  chk_fifo_bound: assert property (@(posedge mclk) disable iff (!resetn)
    r.cnt <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

/* hdl/sipc_params.svh */
// Constants for the servo command-line position decoder.
`ifndef SIPC_PARAMS_SVH
`define SIPC_PARAMS_SVH
`define SIPC_CLK_HZ      50000000
`define SIPC_LOSS_MS     50
`define SIPC_LOSS_CYC    (`SIPC_CLK_HZ / 1000 * `SIPC_LOSS_MS)
`define SIPC_MAX_STOPS   16
`define SIPC_FIFO_DEPTH  8
`define SIPC_CNT_W       22
`define SIPC_DIV_N       40
`define SIPC_DEN_W       24
`define SIPC_FRAC_SH     16
`define SIPC_FRAC_MAX    16'hffff
`endif

/* hdl/sipc_pkg.sv */
// Types shared by the servo command-line position decoder.
package sipc_pkg;
  `include "sipc_params.svh"

  typedef enum logic [2:0] {
    SIPC_M_BURST = 3'h0,
    SIPC_M_MS_BI = 3'h1,
    SIPC_M_MS_SL = 3'h2,
    SIPC_M_MS_HS = 3'h3,
    SIPC_M_PWM   = 3'h4,
    SIPC_M_FREQ  = 3'h5
  } sipc_mode_e;

  typedef enum logic [1:0] {
    SIPC_MS_IDLE = 2'h0,
    SIPC_MS_RUN  = 2'h1,
    SIPC_MS_STOP = 2'h3
  } sipc_ms_e;

  typedef enum logic [1:0] {
    SIPC_DV_IDLE = 2'h0,
    SIPC_DV_P1   = 2'h1,
    SIPC_DV_P2   = 2'h3
  } sipc_dv_e;

  typedef struct packed {
    logic [2:0]             s1, s2, s3, filt;
    logic [15:0]            low_cnt;
    logic                   energized, alt_pend, alt_speed, homed, homed_once, home_req;
    sipc_ms_e               ms;
    logic                   move_run, move_dir, decel;
    logic [4:0]             trig_cnt, sens_cnt, q_cnt;
    logic                   q_dir, overrun, rev_tick;
    logic [15:0]            rev_cnt;
    logic [`SIPC_CNT_W-1:0] per_cnt, high_cnt, high_lat, idle_cnt;
    logic                   fault;
    sipc_dv_e               dv;
    logic [5:0]             dv_cnt;
    logic [`SIPC_DEN_W:0]   rem;
    logic [`SIPC_DIV_N-1:0] quo;
    logic [`SIPC_DEN_W-1:0] den;
    logic [15:0]            target;
  } sipc_st_s;
endpackage

/* test/sipc_ctrl_model.sv */
// Controller model that drives the enable and command lines of the decoder.
`timescale 1ns/10ps
module sipc_ctrl_model #(
  parameter int PHASE = 38
) (
  // Clock
  input  wire logic mclk,
  // Command pins
  output logic      enable_in,
  output logic      line_a_in,
  output logic      line_b_in
);
  initial begin
    enable_in = 1'b0;
    line_a_in = 1'b0;
    line_b_in = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic en(input logic v);
    @(posedge mclk);
    enable_in <= v;
    hold(PHASE);
  endtask

  task automatic set_a(input logic v);
    @(posedge mclk);
    line_a_in <= v;
    hold(PHASE);
  endtask

  // A short drop of enable current; a long one is a disable.
  task automatic trig(input int low);
    @(posedge mclk);
    enable_in <= 1'b0;
    hold(low);
    enable_in <= 1'b1;
    hold(PHASE);
  endtask

  // Each phase lasts 760 ns, so the burst also outruns any speed limit.
  task automatic pulses(input logic dir, input int n);
    set_a(dir);
    repeat (n) begin
      line_b_in <= 1'b1;
      hold(PHASE);
      line_b_in <= 1'b0;
      hold(PHASE);
    end
  endtask

  // Periodic command wave; the PWM tests run it at 312.5 kHz, above the 30 kHz PWM limit.
  task automatic wave(input int hi, input int lo, input int n);
    @(posedge mclk);
    repeat (n) begin
      line_b_in <= 1'b1;
      hold(hi);
      line_b_in <= 1'b0;
      hold(lo);
    end
  endtask
endmodule

/* test/tb_top.sv */
// Self-checking bench for the servo command-line decoder.
`timescale 1ns/10ps
module tb_top;
  import sipc_pkg::*;
  logic        mclk, resetn, home_done, motion_stopped, step_ready;
  logic        enable_in, line_a_in, line_b_in;
  logic [2:0]  cfg_mode;
  logic [15:0] cfg_pos0, cfg_pos1, cfg_trig_width;
  logic [19:0] cfg_freq_min, cfg_freq_max;
  logic        cfg_a_rise, cfg_fixed_dir, cfg_home_every;
  logic        energized, alt_speed, home_req, move_run, move_dir, decel_req;
  logic        step_valid, step_dir, rev_tick, burst_overrun, cmd_fault;
  logic [15:0] target_pos;
  logic        steps[$];
  int          ticks, decels, fails, check_count, cyc;

  sipc_ctrl_model i_ctl (.mclk(mclk), .enable_in(enable_in), .line_a_in(line_a_in),
                         .line_b_in(line_b_in));

  sipc_decoder #(.LOSS_CYC(1000)) i_dut (
    .mclk(mclk), .resetn(resetn), .enable_in(enable_in), .line_a_in(line_a_in),
    .line_b_in(line_b_in), .cfg_mode(cfg_mode), .cfg_trig_width(cfg_trig_width),
    .cfg_resolution(16'h0004), .cfg_a_rise(cfg_a_rise), .cfg_fixed_dir(cfg_fixed_dir),
    .cfg_home_every(cfg_home_every), .cfg_pos0(cfg_pos0), .cfg_pos1(cfg_pos1),
    .cfg_freq_min(cfg_freq_min), .cfg_freq_max(cfg_freq_max), .home_done(home_done),
    .motion_stopped(motion_stopped), .step_ready(step_ready), .energized(energized),
    .alt_speed(alt_speed), .home_req(home_req), .move_run(move_run), .move_dir(move_dir),
    .decel_req(decel_req), .step_valid(step_valid), .step_dir(step_dir),
    .rev_tick(rev_tick), .burst_overrun(burst_overrun), .cmd_fault(cmd_fault),
    .target_pos(target_pos));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Accepted steps, revolution ticks and stop requests are tallied as they appear.
  always @(posedge mclk) begin
    if (step_valid === 1'b1 && step_ready === 1'b1) steps.push_back(step_dir);
    if (rev_tick === 1'b1) ticks++;
    if (decel_req === 1'b1) decels++;
    cyc++;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Wide enough for a flag packed above a full position word.
  task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // A long low on enable drops the motor before the mode is changed.
  task automatic switch_mode(input logic [2:0] m);
    i_ctl.trig(60);
    i_ctl.en(1'b0);
    cfg_mode <= m;
    i_ctl.en(1'b1);
  endtask

  task automatic t_burst();
    steps.delete();
    ticks = 0;
    i_ctl.pulses(1'b1, 3);
    i_ctl.pulses(1'b0, 2);
    i_ctl.hold(10);
    chk(16'(steps.size()), 16'h0005, "step count");
    chk({steps[0], steps[1], steps[2], steps[3], steps[4]}, 16'h001c, "step dirs");
    chk(16'(ticks), 16'h0001, "revolution ticks");
    i_ctl.trig(10);
    chk(energized, 1'b1, "trigger kept motor energized");
    i_ctl.pulses(1'b1, 1);
    chk(alt_speed, 1'b1, "alternate speed move");
    i_ctl.pulses(1'b1, 1);
    chk(alt_speed, 1'b0, "alternate speed for one move only");
  endtask

  // The consumer stalls while the buffer fills, then drains it.
  task automatic t_fifo();
    steps.delete();
    step_ready <= 1'b0;
    i_ctl.pulses(1'b1, 10);
    chk(burst_overrun, 1'b1, "overrun when full");
    step_ready <= 1'b1;
    i_ctl.hold(30);
    chk(16'(steps.size()), 16'h0009, "words held");
    i_ctl.en(1'b0);
    chk(energized, 1'b0, "long low disables");
    chk(burst_overrun, 1'b0, "disable clears overrun");
    i_ctl.en(1'b1);
  endtask

  task automatic t_sensor();
    switch_mode(3'h1);
    chk(home_req, 1'b1, "homing before moves");
    i_ctl.trig(10);
    chk(move_run, 1'b0, "no move before homing");
    home_done <= 1'b1;
    i_ctl.hold(1);
    home_done <= 1'b0;
    i_ctl.hold(6);
    chk(home_req, 1'b0, "homing done");
    i_ctl.set_a(1'b1);
    i_ctl.trig(10);
    i_ctl.trig(10);
    chk({move_run, move_dir}, 2'b11, "move toward line_a");
    decels = 0;
    i_ctl.pulses(1'b1, 1);
    chk(move_run, 1'b1, "second sensor still ahead");
    i_ctl.set_a(1'b0);
    i_ctl.trig(10);
    chk(move_dir, 1'b1, "reverse waits");
    i_ctl.pulses(1'b0, 1);
    chk({move_run, 16'(decels)}, 16'h0001, "stop at matching count");
    motion_stopped <= 1'b1;
    i_ctl.hold(6);
    motion_stopped <= 1'b0;
    chk({move_run, move_dir}, 2'b10, "queued reverse starts");
  endtask

  task automatic t_pwm();
    switch_mode(3'h4);
    i_ctl.wave(40, 120, 6);
    chk(target_pos, 16'h0400, "quarter duty");
    i_ctl.set_a(1'b1);
    i_ctl.wave(80, 80, 4);
    chk(target_pos, 16'h0400, "locked position");
    i_ctl.set_a(1'b0);
    i_ctl.hold(1100);
    chk({cmd_fault, target_pos}, 17'h10400, "loss of modulation");
    i_ctl.wave(80, 80, 5);
    chk({cmd_fault, target_pos}, 17'h00800, "half duty after loss");
  endtask

  task automatic t_freq();
    cfg_pos0 <= 16'h0200;
    switch_mode(3'h5);
    i_ctl.wave(40, 40, 5);
    chk(target_pos, 16'h1000, "above maximum gives position 1");
    i_ctl.wave(100, 100, 5);
    chk(16'(target_pos >= 16'h073f && target_pos <= 16'h0741), 16'h0001, "mid frequency");
  endtask

  // One-way modes: homing on every enable, fixed direction, sensorless start on a falling line_a, home-to-sensor start on triggers.
  task automatic t_uni();
    decels = 0;
    cfg_a_rise <= 1'b0;
    cfg_fixed_dir <= 1'b1;
    cfg_home_every <= 1'b1;
    switch_mode(3'h2);
    chk(home_req, 1'b1, "homing on every enable");
    home_done <= 1'b1;
    i_ctl.hold(1);
    home_done <= 1'b0;
    i_ctl.set_a(1'b1);
    chk(move_run, 1'b0, "wrong line_a edge ignored");
    i_ctl.trig(10);
    i_ctl.set_a(1'b0);
    chk({move_run, move_dir, alt_speed}, 3'b111, "fixed move, alternate speed");
    i_ctl.pulses(1'b0, 1);
    chk({move_run, 16'(decels)}, 17'h00001, "sensorless stop at count");
    switch_mode(3'h3);
    chk(home_req, 1'b1, "homing again after enable");
    home_done <= 1'b1;
    i_ctl.hold(1);
    home_done <= 1'b0;
    // A low of 40 cycles would disable at the old width; now it must be a trigger.
    cfg_trig_width <= 16'h0030;
    i_ctl.trig(40);
    i_ctl.trig(40);
    chk({energized, move_run, move_dir}, 3'b111, "wider trigger setting");
    i_ctl.pulses(1'b0, 1);
    chk(move_run, 1'b1, "rapid triggers extend the move");
    i_ctl.pulses(1'b0, 1);
    chk({move_run, 16'(decels)}, 17'h00002, "home-to-sensor stop");
  endtask

  initial begin
    resetn = 1'b0;
    home_done = 1'b0;
    motion_stopped = 1'b0;
    step_ready = 1'b1;
    cfg_mode = 3'h0;
    cfg_pos0 = 16'h0000;
    cfg_pos1 = 16'h1000;
    cfg_trig_width = 16'h0014;
    cfg_freq_min = 20'h186a0;
    cfg_freq_max = 20'h7a120;
    cfg_a_rise = 1'b1;
    cfg_fixed_dir = 1'b0;
    cfg_home_every = 1'b0;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    chk({energized, move_run, step_valid, target_pos}, 16'h0000, "reset outputs");
    i_ctl.en(1'b1);
    chk(energized, 1'b1, "enable energizes");
    t_burst();
    t_fifo();
    t_sensor();
    t_pwm();
    t_freq();
    t_uni();
    results();
  end
endmodule
